//--- rtl/drive_level_detectors.sv
// Frequency and current level detectors with PID display scaling.
`timescale 1ns/10ps
// How it works
// - Frequency flag sets above level, clears below level-hysteresis.
// - Three frequency detectors share one hysteresis.
// - Frequency levels and hysteresis limited to 0-500 Hz.
// - Current level zero disables; else 1-200 %.
// - Current timers accepted from 0.01 to 600 s.
// - Overload warning follows level one without timer.
// - Over-current flags need level exceeded for timer.
// - Over-current flags clear below 90 % of level.
// - Current flags stay on at least 100 ms.
// - Low-current flag after level two undershoot timer.
// - Low-current clears above level plus 5 %.
// - Motor cooling type accepts values one or two.
// - Thermal time constant accepted 0.5-75 min.
// - Process PID display scales percent between B and A.
// - Display coefficients accepted from -999 to 9990.
// - Dancer mode maps A to +100 %, B -100 %.
// - Monitored values pass a programmable display filter.
module drive_level_detectors
  import drive_pkg::*;
#(
  parameter int TIMEBASE_CYC      = TIMEBASE_NS / CLK_PERIOD_NS,
  parameter int SAMPLES_PER_100MS = 100
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [31:0]        hrdata,
  // Measurements from the drive core
  input  wire logic               sample_tick,
  input  wire logic [15:0]        out_freq,
  input  wire logic [15:0]        out_current,
  input  wire logic signed [15:0] pid_cmd_pct,
  input  wire logic signed [15:0] pid_fb_pct,
  input  wire logic [15:0]        monitor_value,
  // Status flags
  output logic                    freq_level_flag1,
  output logic                    freq_level_flag2,
  output logic                    freq_level_flag3,
  output logic                    overload_warning_flag,
  output logic                    current_high_flag1,
  output logic                    current_high_flag2,
  output logic                    current_high_flag3,
  output logic                    current_low_flag,
  // Display values
  output logic signed [31:0]      pid_cmd_disp,
  output logic signed [31:0]      pid_fb_disp,
  output logic      [15:0]        monitor_disp
);

  localparam int TB_W = $clog2(TIMEBASE_CYC + 1);

  // Settings.
  logic [15:0]        freq_level_ff [3];
  logic [15:0]        freq_hyst_ff;
  logic [15:0]        cur_level_ff [3];
  logic [15:0]        cur_timer_ff [3];
  logic [1:0]         motor_cooling_type_ff;
  logic [9:0]         thermal_time_constant_ff;
  logic signed [15:0] coef_a_ff;
  logic signed [15:0] coef_b_ff;
  logic [5:0]         filter_tc_ff;
  logic [1:0]         pid_mode_ff;

  // Bus state.
  logic               wr_pend_ff;
  logic               rd_pend_ff;
  logic [7:0]         addr_ff;
  logic [31:0]        hrdata_ff;
  logic [31:0]        rd_mux;
  logic               addr_ph;

  // Detector state; channels 0-2 are over-current, 3 is low-current.
  logic [TB_W-1:0]    tb_cnt_ff;
  logic               tb_pulse;
  logic [2:0]         fflag_ff;
  logic               ol_ff;
  logic [3:0]         trig_ff;
  logic [3:0]         clr_ff;
  logic [3:0]         qflag_ff;
  logic [15:0]        qual_cnt_ff [4];
  logic [3:0]         hold_cnt_ff [4];
  logic [15:0]        ch_level [4];
  logic [15:0]        ch_timer [4];

  function automatic logic in_range(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = $signed(v) >= $signed(lo) && $signed(v) <= $signed(hi);
  endfunction : in_range

  function automatic logic signed [31:0] pid_scale(
      input logic signed [15:0] pct,
      input logic [1:0]         mode,
      input logic signed [15:0] a,
      input logic signed [15:0] b);
    logic signed [39:0] span;
    logic signed [39:0] prod;
    span = 40'(a) - 40'(b);
    if (mode == PID_MODE_DANCER) begin
      prod = (40'(pct) + PCT_FULL) * span / PCT_SPAN;
    end else begin
      prod = 40'(pct) * span / PCT_FULL;
    end
    pid_scale = 32'(prod + 40'(b));
  endfunction : pid_scale

  // Reads take one wait state so a write just before is seen.
  assign addr_ph   = hsel && hready && htrans[1];
  assign hreadyout = !rd_pend_ff;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ph && hwrite;
      rd_pend_ff <= addr_ph && !hwrite;
      if (addr_ph) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  // Out-of-range writes are dropped and the old setting kept.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      freq_level_ff            <= '{default: 16'h0000};
      freq_hyst_ff             <= 16'h0000;
      cur_level_ff             <= '{default: 16'h0000};
      cur_timer_ff             <= '{default: RST_TIMER};
      motor_cooling_type_ff    <= RST_COOLING;
      thermal_time_constant_ff <= RST_TTC;
      coef_a_ff                <= RST_COEF_A;
      coef_b_ff                <= 16'h0000;
      filter_tc_ff             <= 6'h00;
      pid_mode_ff              <= 2'h0;
    end else if (wr_pend_ff) begin
      case (addr_ff)
        OFS_FREQ_LEVEL1, OFS_FREQ_LEVEL2, OFS_FREQ_LEVEL3: begin
          if (in_range(hwdata, ZERO32, FREQ_MAX)) begin
            freq_level_ff[addr_ff[3:2]] <= hwdata[15:0];
          end
        end
        OFS_FREQ_HYST: begin
          if (in_range(hwdata, ZERO32, FREQ_MAX)) begin
            freq_hyst_ff <= hwdata[15:0];
          end
        end
        OFS_CUR_LEVEL1, OFS_CUR_LEVEL2, OFS_CUR_LEVEL3: begin
          if (hwdata == ZERO32 || in_range(hwdata, CUR_MIN, CUR_MAX)) begin
            cur_level_ff[2'(addr_ff[4:3] - 2'h2)] <= hwdata[15:0];
          end
        end
        OFS_CUR_TIMER1, OFS_CUR_TIMER2, OFS_CUR_TIMER3: begin
          if (in_range(hwdata, TMR_MIN, TMR_MAX)) begin
            cur_timer_ff[2'(addr_ff[4:3] - 2'h2)] <= hwdata[15:0];
          end
        end
        OFS_COOLING: begin
          if (in_range(hwdata, COOL_MIN, COOL_MAX)) begin
            motor_cooling_type_ff <= hwdata[1:0];
          end
        end
        OFS_THERMAL_TC: begin
          if (in_range(hwdata, TTC_MIN, TTC_MAX)) begin
            thermal_time_constant_ff <= hwdata[9:0];
          end
        end
        OFS_COEF_A: begin
          if (in_range(hwdata, COEF_MIN, COEF_MAX)) begin
            coef_a_ff <= hwdata[15:0];
          end
        end
        OFS_COEF_B: begin
          if (in_range(hwdata, COEF_MIN, COEF_MAX)) begin
            coef_b_ff <= hwdata[15:0];
          end
        end
        OFS_FILTER_TC: begin
          if (in_range(hwdata, ZERO32, FILT_MAX)) begin
            filter_tc_ff <= hwdata[5:0];
          end
        end
        OFS_PID_MODE: begin
          if (in_range(hwdata, ZERO32, MODE_MAX)) begin
            pid_mode_ff <= hwdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (addr_ff)
      OFS_FREQ_LEVEL1:  rd_mux = 32'(freq_level_ff[0]);
      OFS_FREQ_LEVEL2:  rd_mux = 32'(freq_level_ff[1]);
      OFS_FREQ_LEVEL3:  rd_mux = 32'(freq_level_ff[2]);
      OFS_FREQ_HYST:    rd_mux = 32'(freq_hyst_ff);
      OFS_CUR_LEVEL1:   rd_mux = 32'(cur_level_ff[0]);
      OFS_CUR_TIMER1:   rd_mux = 32'(cur_timer_ff[0]);
      OFS_CUR_LEVEL2:   rd_mux = 32'(cur_level_ff[1]);
      OFS_CUR_TIMER2:   rd_mux = 32'(cur_timer_ff[1]);
      OFS_CUR_LEVEL3:   rd_mux = 32'(cur_level_ff[2]);
      OFS_CUR_TIMER3:   rd_mux = 32'(cur_timer_ff[2]);
      OFS_COOLING:      rd_mux = 32'(motor_cooling_type_ff);
      OFS_THERMAL_TC:   rd_mux = 32'(thermal_time_constant_ff);
      OFS_COEF_A:       rd_mux = 32'(coef_a_ff);
      OFS_COEF_B:       rd_mux = 32'(coef_b_ff);
      OFS_FILTER_TC:    rd_mux = 32'(filter_tc_ff);
      OFS_PID_MODE:     rd_mux = 32'(pid_mode_ff);
      OFS_STATUS:       rd_mux = 32'({qflag_ff, ol_ff, fflag_ff});
      OFS_PID_CMD_DISP: rd_mux = pid_cmd_disp;
      OFS_PID_FB_DISP:  rd_mux = pid_fb_disp;
      OFS_MON_DISP:     rd_mux = 32'(monitor_disp);
      default:          rd_mux = ZERO32;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata_ff <= ZERO32;
    end else if (rd_pend_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  // Timer base of one hundredth of a second.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tb_cnt_ff <= '0;
    end else if (tb_pulse) begin
      tb_cnt_ff <= '0;
    end else begin
      tb_cnt_ff <= tb_cnt_ff + 1'b1;
    end
  end
  assign tb_pulse = tb_cnt_ff == TB_W'(TIMEBASE_CYC - 1);

  // Frequency detectors with one shared hysteresis.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_freq
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          fflag_ff[gi] <= 1'b0;
        end else if (sample_tick) begin
          if (out_freq > freq_level_ff[gi]) begin
            fflag_ff[gi] <= 1'b1;
          end else if (17'(out_freq) + 17'(freq_hyst_ff)
                       < 17'(freq_level_ff[gi])) begin
            fflag_ff[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ol_ff <= 1'b0;
    end else if (sample_tick) begin
      ol_ff <= cur_level_ff[0] != 16'h0000
            && out_current > cur_level_ff[0];
    end
  end

  // Low-current shares level and timer two.
  assign ch_level = '{cur_level_ff[0], cur_level_ff[1], cur_level_ff[2],
                      cur_level_ff[1]};
  assign ch_timer = '{cur_timer_ff[0], cur_timer_ff[1], cur_timer_ff[2],
                      cur_timer_ff[1]};

  generate
    for (gi = 0; gi < 4; gi++) begin : g_cur
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          trig_ff[gi] <= 1'b0;
          clr_ff[gi]  <= 1'b0;
        end else if (sample_tick) begin
          if (gi < 3) begin
            trig_ff[gi] <= ch_level[gi] != 16'h0000
                        && out_current > ch_level[gi];
            clr_ff[gi]  <= 20'(out_current) * 20'(DROP_DEN)
                        < 20'(ch_level[gi]) * 20'(DROP_NUM);
          end else begin
            trig_ff[gi] <= ch_level[gi] != 16'h0000
                        && out_current < ch_level[gi];
            clr_ff[gi]  <= 17'(out_current)
                        > 17'(ch_level[gi]) + LOW_MARGIN;
          end
        end
      end

      // The qualifying count restarts whenever the trigger lapses.
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          qual_cnt_ff[gi] <= 16'h0000;
        end else if (!trig_ff[gi]) begin
          qual_cnt_ff[gi] <= 16'h0000;
        end else if (tb_pulse && qual_cnt_ff[gi] < ch_timer[gi]) begin
          qual_cnt_ff[gi] <= qual_cnt_ff[gi] + 16'h0001;
        end
      end

      // Setting wins over clearing in the same cycle.
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          qflag_ff[gi]    <= 1'b0;
          hold_cnt_ff[gi] <= 4'h0;
        end else if (trig_ff[gi] && qual_cnt_ff[gi] >= ch_timer[gi]) begin
          qflag_ff[gi] <= 1'b1;
          if (!qflag_ff[gi]) begin
            hold_cnt_ff[gi] <= 4'h0;
          end else if (tb_pulse && hold_cnt_ff[gi] < MIN_ON_UNITS) begin
            hold_cnt_ff[gi] <= hold_cnt_ff[gi] + 4'h1;
          end
        end else if (qflag_ff[gi]) begin
          if (clr_ff[gi] && hold_cnt_ff[gi] >= MIN_ON_UNITS) begin
            qflag_ff[gi] <= 1'b0;
          end else if (tb_pulse && hold_cnt_ff[gi] < MIN_ON_UNITS) begin
            hold_cnt_ff[gi] <= hold_cnt_ff[gi] + 4'h1;
          end
        end
      end

      qual_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(qflag_ff[gi]) |-> $past(trig_ff[gi])
          && $past(qual_cnt_ff[gi]) >= $past(ch_timer[gi]))
        else $error("Current flag set before its timer expired.");

      min_on_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(qflag_ff[gi]) |-> $past(hold_cnt_ff[gi]) >= MIN_ON_UNITS
          && $past(clr_ff[gi]))
        else $error("Current flag cleared too early or without cause.");
    end
  endgenerate

  // Display values, refreshed once per sample.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pid_cmd_disp <= 32'h0000_0000;
      pid_fb_disp  <= 32'h0000_0000;
    end else if (sample_tick) begin
      pid_cmd_disp <= pid_scale(pid_cmd_pct, pid_mode_ff,
                                coef_a_ff, coef_b_ff);
      pid_fb_disp  <= pid_scale(pid_fb_pct, pid_mode_ff,
                                coef_a_ff, coef_b_ff);
    end
  end

  display_lpf #(
    .W                (16),
    .FRAC             (16),
    .SAMPLES_PER_UNIT (SAMPLES_PER_100MS)
  ) u_mon_lpf (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .sample_tick (sample_tick),
    .tc          (filter_tc_ff),
    .value_in    (monitor_value),
    .value_out   (monitor_disp)
  );

  assign freq_level_flag1      = fflag_ff[0];
  assign freq_level_flag2      = fflag_ff[1];
  assign freq_level_flag3      = fflag_ff[2];
  assign overload_warning_flag = ol_ff;
  assign current_high_flag1    = qflag_ff[0];
  assign current_high_flag2    = qflag_ff[1];
  assign current_high_flag3    = qflag_ff[2];
  assign current_low_flag      = qflag_ff[3];

  freq_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    sample_tick && out_freq > freq_level_ff[0] |=> freq_level_flag1)
    else $error("Frequency flag one missed a rise above level.");

  freq_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(freq_level_flag2) |-> $past(sample_tick)
      && 17'($past(out_freq)) + 17'($past(freq_hyst_ff))
       < 17'($past(freq_level_ff[1])))
    else $error("Frequency flag two cleared inside hysteresis.");

  freq_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    freq_hyst_ff <= FREQ_MAX[15:0] && freq_level_ff[0] <= FREQ_MAX[15:0])
    else $error("Frequency setting beyond its range.");

  ol_track_a: assert property (@(posedge clk_sys) disable iff (rst)
    sample_tick |=> overload_warning_flag ==
      ($past(out_current) > $past(cur_level_ff[0])
       && $past(cur_level_ff[0]) != 16'h0000))
    else $error("Overload warning does not follow current level one.");

  low_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(current_low_flag) |-> $past(clr_ff[3]))
    else $error("Low-current flag cleared without margin exceeded.");

  read_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
    addr_ph && !hwrite |=> !hreadyout ##1 hreadyout && hrdata == $past(rd_mux))
    else $error("Read data phase not one wait state.");

endmodule : drive_level_detectors

//--- rtl/drive_pkg.sv
// Constants shared by the drive level detector design.
package drive_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_FREQ_LEVEL1  = 8'h00;
  localparam logic [7:0] OFS_FREQ_LEVEL2  = 8'h04;
  localparam logic [7:0] OFS_FREQ_LEVEL3  = 8'h08;
  localparam logic [7:0] OFS_FREQ_HYST    = 8'h0C;
  localparam logic [7:0] OFS_CUR_LEVEL1   = 8'h10;
  localparam logic [7:0] OFS_CUR_TIMER1   = 8'h14;
  localparam logic [7:0] OFS_CUR_LEVEL2   = 8'h18;
  localparam logic [7:0] OFS_CUR_TIMER2   = 8'h1C;
  localparam logic [7:0] OFS_CUR_LEVEL3   = 8'h20;
  localparam logic [7:0] OFS_CUR_TIMER3   = 8'h24;
  localparam logic [7:0] OFS_COOLING      = 8'h28;
  localparam logic [7:0] OFS_THERMAL_TC   = 8'h2C;
  localparam logic [7:0] OFS_COEF_A       = 8'h30;
  localparam logic [7:0] OFS_COEF_B       = 8'h34;
  localparam logic [7:0] OFS_FILTER_TC    = 8'h38;
  localparam logic [7:0] OFS_PID_MODE     = 8'h3C;
  localparam logic [7:0] OFS_STATUS       = 8'h40;
  localparam logic [7:0] OFS_PID_CMD_DISP = 8'h44;
  localparam logic [7:0] OFS_PID_FB_DISP  = 8'h48;
  localparam logic [7:0] OFS_MON_DISP     = 8'h4C;

  // Accepted write ranges; units are 0.1 Hz, 0.01 %, 0.01 s, 0.1 min, 0.1 s.
  localparam logic [31:0] ZERO32    = 32'h0000_0000;
  localparam logic [31:0] FREQ_MAX  = 32'h0000_1388;
  localparam logic [31:0] CUR_MIN   = 32'h0000_0064;
  localparam logic [31:0] CUR_MAX   = 32'h0000_4E20;
  localparam logic [31:0] TMR_MIN   = 32'h0000_0001;
  localparam logic [31:0] TMR_MAX   = 32'h0000_EA60;
  localparam logic [31:0] COOL_MIN  = 32'h0000_0001;
  localparam logic [31:0] COOL_MAX  = 32'h0000_0002;
  localparam logic [31:0] TTC_MIN   = 32'h0000_0005;
  localparam logic [31:0] TTC_MAX   = 32'h0000_02EE;
  localparam logic [31:0] COEF_MIN  = 32'hFFFF_FC19;
  localparam logic [31:0] COEF_MAX  = 32'h0000_2706;
  localparam logic [31:0] FILT_MAX  = 32'h0000_0032;
  localparam logic [31:0] MODE_MAX  = 32'h0000_0003;

  // Reset values.
  localparam logic [15:0] RST_TIMER   = 16'h0001;
  localparam logic [1:0]  RST_COOLING = 2'h1;
  localparam logic [9:0]  RST_TTC     = 10'h005;
  localparam logic [15:0] RST_COEF_A  = 16'h0064;

  // PID display modes.
  localparam logic [1:0] PID_MODE_DANCER = 2'h3;

  // Scaling figures, 0.01 % units.
  localparam logic signed [39:0] PCT_FULL   = 40'sh00_0000_2710;
  localparam logic signed [39:0] PCT_SPAN   = 40'sh00_0000_4E20;
  localparam logic [16:0]        LOW_MARGIN = 17'h0_01F4;
  localparam logic [3:0]         DROP_NUM   = 4'h9;
  localparam logic [3:0]         DROP_DEN   = 4'hA;

  // Timing.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TIMEBASE_NS    = 10_000_000;
  localparam int MIN_ON_MS      = 100;
  localparam int TIMER_UNIT_MS  = 10;
  localparam logic [3:0] MIN_ON_UNITS = 4'(MIN_ON_MS / TIMER_UNIT_MS);

endpackage : drive_pkg

//--- rtl/display_lpf.sv
// First-order low-pass filter for monitored display values.
`timescale 1ns/10ps
module display_lpf
  import drive_pkg::*;
#(
  parameter int W                = 16,
  parameter int FRAC             = 16,
  parameter int SAMPLES_PER_UNIT = 100
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Sample stream
  input  wire logic         sample_tick,
  input  wire logic [5:0]   tc,
  input  wire logic [W-1:0] value_in,
  output logic      [W-1:0] value_out
);

  logic [W+FRAC-1:0]      acc_ff;
  logic [31:0]            divisor;
  logic signed [W+FRAC:0] diff;
  logic signed [W+FRAC:0] step;

  // The divisor is the time constant counted in samples, plus one.
  assign divisor = 32'(tc) * 32'(SAMPLES_PER_UNIT) + 32'h0000_0001;
  assign diff = $signed({1'b0, value_in, {FRAC{1'b0}}})
              - $signed({1'b0, acc_ff});
  assign step = (W+FRAC+1)'(diff / $signed({1'b0, divisor}));

  // Fractional bits keep small steps from stalling the output.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (sample_tick) begin
      if (tc == 6'h00) begin
        acc_ff <= {value_in, {FRAC{1'b0}}};
      end else begin
        acc_ff <= (W+FRAC)'($signed({1'b0, acc_ff}) + step);
      end
    end
  end

  assign value_out = acc_ff[W+FRAC-1:FRAC];

  filter_pass_a: assert property (@(posedge clk_sys) disable iff (rst)
    sample_tick && tc == 6'h00 |=> value_out == $past(value_in))
    else $error("Zero time constant did not pass value through.");

endmodule : display_lpf

//--- verification/tb_top.sv
// Self-checking testbench for the drive level detectors.
`timescale 1ns/10ps
module tb_top;
  import drive_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} acc_t;
  logic               clk_sys = 1'b0;
  logic               rst     = 1'b1;
  logic        [31:0] haddr   = '0;
  logic        [31:0] hwdata  = '0;
  logic        [1:0]  htrans  = '0;
  logic               hwrite  = 1'b0;
  logic               tick    = 1'b1;
  logic        [31:0] hrdata;
  logic        [31:0] rd;
  logic               hreadyout;
  logic               hresp;
  logic        [15:0] freq    = '0;
  logic        [15:0] cur     = '0;
  logic        [15:0] mon     = '0;
  logic signed [15:0] cmd     = '0;
  logic signed [15:0] fb      = '0;
  logic               f1, f2, f3, ol, h1, h2, h3, lo;
  logic        [15:0] mon_d;
  int                 n_fail = 0;
  int                 num_checks = 0;
  acc_t tbl[11] = '{'{OFS_COOLING, 3, 1}, '{OFS_COOLING, 2, 2},
    '{OFS_THERMAL_TC, 4, 5}, '{OFS_THERMAL_TC, 32'h0000_02EE, 32'h0000_02EE},
    '{OFS_FREQ_LEVEL1, 32'h0000_1389, 0}, '{OFS_COEF_A, 32'h0000_2707, 100},
    '{OFS_COEF_B, 32'hFFFF_FC18, 0}, '{OFS_CUR_LEVEL1, 32'h0000_0063, 0},
    '{OFS_CUR_TIMER1, 32'h0000_EA61, 1}, '{OFS_CUR_TIMER1, 0, 1},
    '{8'h50, 5, 0}};
  logic [15:0] fv[7] = '{16'h09C4, 16'h079E, 16'h076B, 16'h03E7, 16'h0383,
    16'h0BB9, 16'h0000};
  logic [7:0]  fe[7] = '{8'h03, 8'h03, 8'h01, 8'h01, 8'h00, 8'h07, 8'h00};

  drive_level_detectors #(.TIMEBASE_CYC(10)) dut_u (.clk_sys(clk_sys),
    .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sample_tick(tick), .out_freq(freq), .out_current(cur),
    .pid_cmd_pct(cmd), .pid_fb_pct(fb), .monitor_value(mon),
    .freq_level_flag1(f1), .freq_level_flag2(f2), .freq_level_flag3(f3),
    .overload_warning_flag(ol), .current_high_flag1(h1),
    .current_high_flag2(h2), .current_high_flag3(h3),
    .current_low_flag(lo), .pid_cmd_disp(), .pid_fb_disp(),
    .monitor_disp(mon_d));

  always #5 clk_sys = ~clk_sys;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      n_fail++;
    end
  endtask : chk

  // Ready is sampled mid-cycle, where it has settled, and acted on at
  // the following rising edge.
  task automatic hold;
    int   k;
    logic rdy;
    k = 0;
    do begin
      @(negedge clk_sys);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge clk_sys);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      complete_run();
    end
  endtask : hold

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    hold();
    htrans <= 2'b00;
    hwdata <= d;
    hold();
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic flg(input logic [7:0] e);
    @(negedge clk_sys);
    chk({24'h0, lo, h3, h2, h1, ol, f3, f2, f1}, {24'h0, e});
    @(posedge clk_sys);
  endtask : flg

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc(OFS_COEF_A, 32'h0000_0064);
    rdc(OFS_CUR_TIMER1, 32'h0000_0001);
    rdc(OFS_COOLING, 32'h0000_0001);
    rdc(OFS_THERMAL_TC, 32'h0000_0005);
    foreach (tbl[i]) begin
      wr(tbl[i].a, tbl[i].d);
      rdc(tbl[i].a, tbl[i].e);
    end
    wr(OFS_FREQ_LEVEL1, 32'h0000_03E8);
    wr(OFS_FREQ_LEVEL2, 32'h0000_07D0);
    wr(OFS_FREQ_LEVEL3, 32'h0000_0BB8);
    wr(OFS_FREQ_HYST, 32'h0000_0064);
    tick <= 1'b0;
    freq <= 16'h09C4;
    cyc(3);
    flg(8'h00);
    tick <= 1'b1;
    foreach (fv[i]) begin
      freq <= fv[i];
      cyc(3);
      flg(fe[i]);
    end
    wr(OFS_CUR_LEVEL1, 32'h0000_1388);
    wr(OFS_CUR_TIMER1, 32'h0000_0005);
    cur <= 16'h1389;
    cyc(3);
    flg(8'h08);
    cur <= 16'h1387;
    cyc(3);
    flg(8'h00);
    cur <= 16'h1389;
    cyc(30);
    flg(8'h08);
    cyc(40);
    flg(8'h18);
    cur <= 16'h1194;
    cyc(150);
    flg(8'h10);
    cur <= 16'h1193;
    cyc(3);
    flg(8'h00);
    wr(OFS_CUR_LEVEL3, 32'h0000_03E8);
    cur <= 16'h07D0;
    cyc(25);
    flg(8'h40);
    cur <= 16'h0000;
    cyc(30);
    flg(8'h40);
    cyc(100);
    flg(8'h00);
    wr(OFS_CUR_LEVEL2, 32'h0000_0BB8);
    wr(OFS_CUR_TIMER2, 32'h0000_0003);
    cyc(8);
    flg(8'h00);
    cyc(40);
    flg(8'h80);
    cur <= 16'h0DAC;
    cyc(150);
    flg(8'hE0);
    cur <= 16'h0DAD;
    cyc(3);
    flg(8'h60);
    cur <= 16'h0000;
    cyc(150);
    flg(8'h80);
    wr(OFS_COEF_A, 32'h0000_012C);
    wr(OFS_COEF_B, 32'hFFFF_FC19);
    cmd <= 16'sh1388;
    fb <= 16'shD8F0;
    for (int m = 1; m < 4; m++) begin
      wr(OFS_PID_MODE, m);
      cyc(3);
      rdc(OFS_PID_CMD_DISP, (m == 3) ? 32'hFFFF_FFE7 : 32'hFFFF_FEA2);
      rdc(OFS_PID_FB_DISP, (m == 3) ? 32'hFFFF_FC19 : 32'hFFFF_F706);
    end
    wr(OFS_COEF_B, 32'hFFFF_FF9C);
    cmd <= 16'sh0000;
    cyc(3);
    rdc(OFS_PID_CMD_DISP, 32'h0000_0064);
    mon <= 16'h1234;
    cyc(3);
    rdc(OFS_MON_DISP, 32'h0000_1234);
    wr(OFS_FILTER_TC, 32'h0000_0001);
    mon <= 16'h0000;
    cyc(5);
    @(negedge clk_sys);
    chk({31'h0, mon_d > 16'h1000}, 32'h0000_0001);
    chk({31'h0, mon_d < 16'h1234}, 32'h0000_0001);
    @(posedge clk_sys);
    complete_run();
  end
endmodule : tb_top
